// ---- src/rcd_pkg.sv ----
// Constants shared by the ring clock divider and oscillation stop detector.
// Assumes an 8-bit register port and oscillator levels synchronous to sys_clk.
package rcd_pkg;
    // ==========================================================
    // Register addresses.
    localparam logic [7:0] ADDR_CPU_MODE = 8'h3B;
    localparam logic [7:0] ADDR_RING_DIV = 8'h39;
    localparam logic [7:0] ADDR_MISC_OSC = 8'h38;

    // ==========================================================
    // Reset values.
    localparam logic [7:0] CPU_MODE_RST = 8'h80;
    localparam logic [1:0] RING_DIV_RST = 2'h2;

    // ==========================================================
    // Field positions of the CPU mode register.
    localparam int CM_DIV_HI = 7;
    localparam int CM_DIV_LO = 6;
    localparam int CM_OSC_SEL = 5;
    localparam int CM_MAIN_STOP = 4;
    localparam int CM_RING_STOP = 3;
    localparam logic [7:0] CM_LOCK_MASK = 8'h23;

    // Field positions of the miscellaneous oscillator control register.
    localparam int MS_DET_ACT = 0;
    localparam int MS_STOP_RST = 1;
    localparam int MS_STOP_STAT = 2;

    // ==========================================================
    // Clock division ratio selection in the CPU mode register.
    localparam logic [1:0] CDIV_HIGH = 2'h0;
    localparam logic [1:0] CDIV_MIDDLE = 2'h1;
    localparam logic [1:0] CDIV_RING = 2'h2;
    localparam logic [1:0] CDIV_DOUBLE = 2'h3;

    // Ring division ratio selection.
    localparam logic [1:0] RDIV_1 = 2'h0;
    localparam logic [1:0] RDIV_2 = 2'h1;
    localparam logic [1:0] RDIV_8 = 2'h2;
    localparam logic [1:0] RDIV_128 = 2'h3;

    // Source edges per half period of the divided clock.
    localparam logic [7:0] HALF_1 = 8'h01;
    localparam logic [7:0] HALF_2 = 8'h02;
    localparam logic [7:0] HALF_8 = 8'h08;
    localparam logic [7:0] HALF_128 = 8'h80;

    // Ring oscillator edges without a main oscillator edge that mean a stop.
    localparam logic [7:0] STOP_LIMIT_EDGES = 8'h40;

    typedef enum logic [1:0] {
        RCD_SRC_RING = 2'b00,
        RCD_SRC_SWITCH = 2'b01,
        RCD_SRC_MAIN = 2'b11
    } rcd_src_e;
endpackage : rcd_pkg

// ---- src/rcd_clk_div.sv ----
// Glitch-free divider of the selected oscillator edge stream.
// Assumes one tick input pulse per edge of each oscillator, in the sys_clk domain.
`timescale 1ns/1ns
module rcd_clk_div (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ring_tick,
    input wire logic main_tick,
    input wire logic sel_main,
    input wire logic [7:0] half_edges,
    output logic clk_r,
    output logic cur_main_r
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] half_r;
    logic [7:0] half_nxt;
    logic clk_nxt;
    logic cur_main_nxt;
    logic tick;

    // ==========================================================
    // Settings change only when a whole low phase ends, so no phase is cut short.
    always_comb
    begin
        tick = cur_main_r ? main_tick : ring_tick;
        cnt_nxt = cnt_r;
        clk_nxt = clk_r;
        half_nxt = half_r;
        cur_main_nxt = cur_main_r;
        if (tick)
        begin
            if (cnt_r + 8'h01 >= half_r)
            begin
                cnt_nxt = 8'h00;
                clk_nxt = ~clk_r;
                if (!clk_r)
                begin
                    half_nxt = half_edges;
                    cur_main_nxt = sel_main;
                end
            end
            else
            begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_r <= 8'h00;
            clk_r <= 1'b0;
            half_r <= rcd_pkg::HALF_8;
            cur_main_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            clk_r <= clk_nxt;
            half_r <= half_nxt;
            cur_main_r <= cur_main_nxt;
        end
    end

    // ==========================================================
    // The divided clock moves only on an edge of its own source.
    edge_only_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !tick |=> $stable(clk_r))
        else $error("divided clock changed without a source edge");
    ratio_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_r |=> $stable(half_r))
        else $error("ratio changed during a high phase");
endmodule : rcd_clk_div

// ---- src/rcd_stop_det.sv ----
// Main oscillator stop detector clocked by ring oscillator edges.
// Assumes edge ticks of both oscillators in the sys_clk domain.
`timescale 1ns/1ns
module rcd_stop_det (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic ring_tick,
    input wire logic main_tick,
    output logic stop_r
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic armed_r;
    logic armed_nxt;
    logic stop_nxt;

    // ==========================================================
    // One pulse per loss; a main oscillator edge rearms the detector.
    always_comb
    begin
        cnt_nxt = cnt_r;
        armed_nxt = armed_r;
        stop_nxt = 1'b0;
        if (!enable || main_tick)
        begin
            cnt_nxt = 8'h00;
            armed_nxt = 1'b1;
        end
        else if (ring_tick && armed_r)
        begin
            if (cnt_r + 8'h01 >= rcd_pkg::STOP_LIMIT_EDGES)
            begin
                stop_nxt = 1'b1;
                armed_nxt = 1'b0;
                cnt_nxt = 8'h00;
            end
            else
            begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_r <= 8'h00;
            armed_r <= 1'b1;
            stop_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            armed_r <= armed_nxt;
            stop_r <= stop_nxt;
        end
    end

    // ==========================================================
    only_enabled_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !$past(enable) |-> !stop_r)
        else $error("stop reported while detector disabled");
endmodule : rcd_stop_det

// ---- src/rcd_top.sv ----
// Clock control: CPU clock selection and division, write-once mode bits,
// and the main oscillator stop detector with its internal reset.
// Assumes a register master on a plain strobe port and oscillator levels
// sampled synchronously to sys_clk, each at most half the sys_clk rate.
//
// Notes on behaviour
// - In ring mode the CPU clock is ring divided by 1, 2, 8 or 128.
// - The ring ratio affects only the CPU clock, never the peripheral clock.
// - After reset the CPU runs from ring divided by eight.
// - Switching from main oscillator back to ring forces ring divided by eight.
// - The stop detector works only while its active bit is one.
// - A detected stop sets the sticky stop status flag.
// - With stop reset enabled, a detected stop also raises an internal reset.
// - The stop status flag survives the internal stop reset.
// - External reset clears the stop status flag.
// - Writing zero to the active bit clears the stop status flag.
// - The internal stop reset leaves the active bit set.
// - Main clock runs at input rate, half rate or eighth rate.
// - Oscillation mode and processor mode bits take one write after reset.
// - CPU mode holds ratio in bits 7:6, main stop bit 4, ring stop bit 3.
// - Start from ring; bit 5 picks ceramic or RC for the main oscillator.
// - Any write to the CPU mode register locks bits 5, 1 and 0.
`timescale 1ns/1ns
module rcd_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ring_osc_in,
    input wire logic main_osc_input,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data_r,
    output logic cpu_clk_r,
    output logic periph_clk_r,
    output logic main_osc_output,
    output logic ring_osc_en_r,
    output logic int_rst_r
);
    // ==========================================================
    // Oscillator edge detection.
    logic ring_q_r;
    logic main_q_r;
    logic ring_tick;
    logic main_tick;

    assign ring_tick = ring_osc_in ^ ring_q_r;
    assign main_tick = main_osc_input ^ main_q_r;

    // ==========================================================
    // Register state.
    logic [7:0] cpu_mode_r;
    logic [7:0] cpu_mode_nxt;
    logic lock_r;
    logic lock_nxt;
    logic [1:0] ring_div_r;
    logic [1:0] ring_div_nxt;
    logic det_act_r;
    logic det_act_nxt;
    logic stop_rst_en_r;
    logic stop_rst_en_nxt;
    logic stop_stat_r;
    logic stop_stat_nxt;
    logic int_rst_nxt;
    logic [7:0] rd_data_nxt;
    logic periph_clk_nxt;
    logic main_osc_out_nxt;
    logic ring_osc_en_nxt;
    rcd_pkg::rcd_src_e src_r;
    rcd_pkg::rcd_src_e src_nxt;

    logic stop_pulse;
    logic cur_main;
    logic wr_cpu_mode;
    logic wr_misc;
    logic [7:0] half_sel;
    logic [7:0] cm_written;

    // Maps a ring ratio selection to source edges per half period.
    function automatic logic [7:0] ring_half(input logic [1:0] sel);
        case (sel)
            rcd_pkg::RDIV_1: ring_half = rcd_pkg::HALF_1;
            rcd_pkg::RDIV_2: ring_half = rcd_pkg::HALF_2;
            rcd_pkg::RDIV_8: ring_half = rcd_pkg::HALF_8;
            default: ring_half = rcd_pkg::HALF_128;
        endcase
    endfunction : ring_half

    // Maps a main clock mode to source edges per half period.
    function automatic logic [7:0] main_half(input logic [1:0] sel);
        case (sel)
            rcd_pkg::CDIV_DOUBLE: main_half = rcd_pkg::HALF_1;
            rcd_pkg::CDIV_HIGH: main_half = rcd_pkg::HALF_2;
            default: main_half = rcd_pkg::HALF_8;
        endcase
    endfunction : main_half

    function automatic logic is_ring(input logic [7:0] mode);
        is_ring = (mode[rcd_pkg::CM_DIV_HI:rcd_pkg::CM_DIV_LO] == rcd_pkg::CDIV_RING);
    endfunction : is_ring

    assign wr_cpu_mode = wr_stb && (addr == rcd_pkg::ADDR_CPU_MODE);
    assign wr_misc = wr_stb && (addr == rcd_pkg::ADDR_MISC_OSC);
    // Locked bits keep their value; the others take the written data.
    assign cm_written = lock_r ? ((wr_data & ~rcd_pkg::CM_LOCK_MASK) | (cpu_mode_r & rcd_pkg::CM_LOCK_MASK))
                               : wr_data;

    // ==========================================================
    // Source selection and division ratio.
    always_comb
    begin
        if (src_r == rcd_pkg::RCD_SRC_RING)
        begin
            half_sel = ring_half(ring_div_r);
        end
        else
        begin
            half_sel = main_half(cpu_mode_r[rcd_pkg::CM_DIV_HI:rcd_pkg::CM_DIV_LO]);
        end
    end

    always_comb
    begin
        src_nxt = src_r;
        case (src_r)
            rcd_pkg::RCD_SRC_RING:
                if (!is_ring(cpu_mode_r))
                begin
                    src_nxt = rcd_pkg::RCD_SRC_SWITCH;
                end
            rcd_pkg::RCD_SRC_SWITCH:
                if (is_ring(cpu_mode_r))
                begin
                    src_nxt = rcd_pkg::RCD_SRC_RING;
                end
                else if (cur_main)
                begin
                    src_nxt = rcd_pkg::RCD_SRC_MAIN;
                end
            rcd_pkg::RCD_SRC_MAIN:
                if (is_ring(cpu_mode_r))
                begin
                    src_nxt = rcd_pkg::RCD_SRC_RING;
                end
            default:
                src_nxt = rcd_pkg::RCD_SRC_RING;
        endcase
        if (int_rst_r)
        begin
            src_nxt = rcd_pkg::RCD_SRC_RING;
        end
    end

    // ==========================================================
    // Register writes, stop flag and internal reset.
    always_comb
    begin
        cpu_mode_nxt = cpu_mode_r;
        lock_nxt = lock_r;
        ring_div_nxt = ring_div_r;
        det_act_nxt = det_act_r;
        stop_rst_en_nxt = stop_rst_en_r;
        stop_stat_nxt = stop_stat_r;
        int_rst_nxt = 1'b0;
        if (wr_cpu_mode)
        begin
            cpu_mode_nxt = cm_written;
            lock_nxt = 1'b1;
            if (!is_ring(cpu_mode_r) && is_ring(cm_written))
            begin
                ring_div_nxt = rcd_pkg::RDIV_8;
            end
        end
        if (wr_stb && (addr == rcd_pkg::ADDR_RING_DIV))
        begin
            ring_div_nxt = wr_data[1:0];
        end
        if (wr_misc)
        begin
            det_act_nxt = wr_data[rcd_pkg::MS_DET_ACT];
            stop_rst_en_nxt = wr_data[rcd_pkg::MS_STOP_RST];
            if (!wr_data[rcd_pkg::MS_DET_ACT])
            begin
                stop_stat_nxt = 1'b0;
            end
        end
        if (stop_pulse)
        begin
            stop_stat_nxt = 1'b1;
            int_rst_nxt = stop_rst_en_r;
        end
        if (int_rst_r)
        begin
            // Internal reset restores clock control but keeps the detector state.
            cpu_mode_nxt = rcd_pkg::CPU_MODE_RST;
            lock_nxt = 1'b0;
            ring_div_nxt = rcd_pkg::RING_DIV_RST;
            det_act_nxt = det_act_r;
            stop_stat_nxt = stop_stat_r | stop_pulse;
        end
    end

    // ==========================================================
    // Read port and registered pin outputs.
    always_comb
    begin
        case (addr)
            rcd_pkg::ADDR_CPU_MODE: rd_data_nxt = cpu_mode_r;
            rcd_pkg::ADDR_RING_DIV: rd_data_nxt = {6'h00, ring_div_r};
            rcd_pkg::ADDR_MISC_OSC: rd_data_nxt = {5'h00, stop_stat_r, stop_rst_en_r, det_act_r};
            default: rd_data_nxt = 8'h00;
        endcase
        if (!rd_stb)
        begin
            rd_data_nxt = 8'h00;
        end
        periph_clk_nxt = cur_main ? main_osc_input : ring_osc_in;
        main_osc_out_nxt = !cpu_mode_r[rcd_pkg::CM_MAIN_STOP];
        ring_osc_en_nxt = !cpu_mode_r[rcd_pkg::CM_RING_STOP];
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ring_q_r <= 1'b0;
            main_q_r <= 1'b0;
            cpu_mode_r <= rcd_pkg::CPU_MODE_RST;
            lock_r <= 1'b0;
            ring_div_r <= rcd_pkg::RING_DIV_RST;
            det_act_r <= 1'b0;
            stop_rst_en_r <= 1'b0;
            stop_stat_r <= 1'b0;
            int_rst_r <= 1'b0;
            rd_data_r <= 8'h00;
            periph_clk_r <= 1'b0;
            main_osc_output <= 1'b1;
            ring_osc_en_r <= 1'b1;
            src_r <= rcd_pkg::RCD_SRC_RING;
        end
        else
        begin
            ring_q_r <= ring_osc_in;
            main_q_r <= main_osc_input;
            cpu_mode_r <= cpu_mode_nxt;
            lock_r <= lock_nxt;
            ring_div_r <= ring_div_nxt;
            det_act_r <= det_act_nxt;
            stop_rst_en_r <= stop_rst_en_nxt;
            stop_stat_r <= stop_stat_nxt;
            int_rst_r <= int_rst_nxt;
            rd_data_r <= rd_data_nxt;
            periph_clk_r <= periph_clk_nxt;
            main_osc_output <= main_osc_out_nxt;
            ring_osc_en_r <= ring_osc_en_nxt;
            src_r <= src_nxt;
        end
    end

    // ==========================================================
    // Divider and stop detector; the internal reset restarts the divider on the ring, even with main stopped.
    rcd_clk_div u_div (
        .sys_clk(sys_clk),
        .nrst(nrst && !int_rst_r),
        .ring_tick(ring_tick),
        .main_tick(main_tick),
        .sel_main(src_r != rcd_pkg::RCD_SRC_RING),
        .half_edges(half_sel),
        .clk_r(cpu_clk_r),
        .cur_main_r(cur_main)
    );

    rcd_stop_det u_det (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .enable(det_act_r),
        .ring_tick(ring_tick),
        .main_tick(main_tick),
        .stop_r(stop_pulse)
    );

    // ==========================================================
    // Checks.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    stat_set_a: assert property (stop_pulse |=> stop_stat_r)
        else $error("stop status not set after stop");
    int_rst_a: assert property (stop_pulse && stop_rst_en_r |=> int_rst_r ##1 !int_rst_r)
        else $error("internal reset not one cycle after stop");
    no_int_rst_a: assert property (!stop_pulse |=> !int_rst_r)
        else $error("internal reset without a stop");
    stat_keep_a: assert property (int_rst_r |=> stop_stat_r)
        else $error("stop status lost in internal reset");
    act_keep_a: assert property (int_rst_r && !wr_misc |=> det_act_r == $past(det_act_r))
        else $error("active bit changed by internal reset");
    stat_clr_a: assert property (wr_misc && !wr_data[0] && !stop_pulse && !int_rst_r |=> !stop_stat_r)
        else $error("stop status not cleared");
    lock_hold_a: assert property (wr_cpu_mode && lock_r && !int_rst_r
        |=> (cpu_mode_r & rcd_pkg::CM_LOCK_MASK) == ($past(cpu_mode_r) & rcd_pkg::CM_LOCK_MASK))
        else $error("locked mode bits changed");
    ring_force_a: assert property (wr_cpu_mode && !is_ring(cpu_mode_r) && is_ring(cm_written) && !int_rst_r
        |=> ring_div_r == rcd_pkg::RDIV_8)
        else $error("ring ratio not forced to eight");
    rst_div_a: assert property (int_rst_r |=> ring_div_r == rcd_pkg::RDIV_8 && is_ring(cpu_mode_r))
        else $error("reset did not select ring by eight");

    stop_rst_c: cover property (stop_pulse && stop_rst_en_r ##1 int_rst_r);
    to_main_c: cover property (src_r == rcd_pkg::RCD_SRC_SWITCH ##[1:1000] src_r == rcd_pkg::RCD_SRC_MAIN);
    back_ring_c: cover property (src_r == rcd_pkg::RCD_SRC_MAIN ##1 src_r == rcd_pkg::RCD_SRC_RING);
endmodule : rcd_top

// ---- testbench/test_ring_clock_divider_and_osc_stop_detect.sv ----
// Self-checking bench for the clock control block: registers, CPU clock ratios,
// write-once mode bits and the oscillation stop detector with its internal reset.
// Assumes rcd_pkg and rcd_top are compiled first; the bench drives all ports itself.
`timescale 1ns/1ns
module test_ring_clock_divider_and_osc_stop_detect;
    logic sys_clk;
    logic nrst;
    logic ring_osc_in;
    logic main_osc_input;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] rd_data_r;
    logic cpu_clk_r;
    logic periph_clk_r;
    logic main_osc_output;
    logic ring_osc_en_r;
    logic int_rst_r;
    logic ring_run;
    logic main_run;
    logic [7:0] rv;
    int n_errors;
    int tests_run;
    int irst_cnt;

    rcd_top uut (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ring_osc_in(ring_osc_in),
        .main_osc_input(main_osc_input),
        .addr(addr),
        .wr_data(wr_data),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .rd_data_r(rd_data_r),
        .cpu_clk_r(cpu_clk_r),
        .periph_clk_r(periph_clk_r),
        .main_osc_output(main_osc_output),
        .ring_osc_en_r(ring_osc_en_r),
        .int_rst_r(int_rst_r)
    );

    // ==========================================================
    // Clock, oscillator models and internal reset pulse counter.
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Each running oscillator changes level once per cycle, one edge tick each.
    always @(posedge sys_clk)
    begin
        if (ring_run)
            ring_osc_in <= ~ring_osc_in;
        if (main_run)
            main_osc_input <= ~main_osc_input;
        if (int_rst_r === 1'b1)
            irst_cnt <= irst_cnt + 1;
    end

    // ==========================================================
    // Bus, comparison and measuring tasks.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        @(negedge sys_clk);
        d = rd_data_r;
    endtask : reg_rd

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        reg_rd(a, d);
        chk(what, exp, d);
    endtask : rd_chk

    task automatic wait_lvl(input logic v);
        int k;
        k = 0;
        while (cpu_clk_r !== v && k < 1000)
        begin
            @(negedge sys_clk);
            k++;
        end
    endtask : wait_lvl

    // Skips two periods so a pending ratio or source change has landed, then times a high phase.
    task automatic half_chk(input string what, input logic [7:0] exp);
        int n;
        repeat (2)
        begin
            wait_lvl(1'b1);
            wait_lvl(1'b0);
        end
        wait_lvl(1'b1);
        n = 0;
        while (cpu_clk_r === 1'b1 && n < 400)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk(what, exp, 8'(n));
    endtask : half_chk

    task automatic do_reset;
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
    endtask : do_reset

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        #(20000 * 40);
        n_errors++;
        $display("CHECK FAILED watchdog expected done seen hang");
        wrap_up();
    end

    // ==========================================================
    // Test sequence.
    initial
    begin
        logic [7:0] p0;
        nrst = 1'b0;
        ring_osc_in = 1'b0;
        main_osc_input = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        ring_run = 1'b1;
        main_run = 1'b1;
        n_errors = 0;
        tests_run = 0;
        irst_cnt = 0;
        do_reset();
        @(negedge sys_clk);
        chk("main_osc_output", 8'h01, {7'h00, main_osc_output});
        chk("ring_osc_en_r", 8'h01, {7'h00, ring_osc_en_r});
        rd_chk("cpu_mode reset", rcd_pkg::ADDR_CPU_MODE, rcd_pkg::CPU_MODE_RST);
        rd_chk("ring_div reset", rcd_pkg::ADDR_RING_DIV, {6'h00, rcd_pkg::RDIV_8});
        rd_chk("misc reset", rcd_pkg::ADDR_MISC_OSC, 8'h00);
        @(negedge sys_clk);
        chk("read data idle", 8'h00, rd_data_r);
        rd_chk("unmapped", 8'h3A, 8'h00);
        half_chk("ring default half", rcd_pkg::HALF_8);
        // Ring ratios, including a change on every step.
        reg_wr(rcd_pkg::ADDR_RING_DIV, {6'h00, rcd_pkg::RDIV_1});
        half_chk("ring /1 half", rcd_pkg::HALF_1);
        reg_wr(rcd_pkg::ADDR_RING_DIV, {6'h00, rcd_pkg::RDIV_2});
        half_chk("ring /2 half", rcd_pkg::HALF_2);
        reg_wr(rcd_pkg::ADDR_RING_DIV, {6'h00, rcd_pkg::RDIV_128});
        half_chk("ring /128 half", rcd_pkg::HALF_128);
        @(negedge sys_clk);
        p0 = {7'h00, periph_clk_r};
        @(negedge sys_clk);
        chk("periph toggles", {7'h00, ~p0[0]}, {7'h00, periph_clk_r});
        // First CPU mode write is the ring-only pattern, then the locked bits hold.
        reg_wr(rcd_pkg::ADDR_CPU_MODE, 8'h90);
        rd_chk("cpu_mode first", rcd_pkg::ADDR_CPU_MODE, 8'h90);
        chk("main drive off", 8'h00, {7'h00, main_osc_output});
        reg_wr(rcd_pkg::ADDR_CPU_MODE, 8'hB7);
        rd_chk("cpu_mode locked", rcd_pkg::ADDR_CPU_MODE, 8'h94);
        chk("ring en", 8'h01, {7'h00, ring_osc_en_r});
        // Main oscillator modes, then the return to ring.
        reg_wr(rcd_pkg::ADDR_RING_DIV, {6'h00, rcd_pkg::RDIV_2});
        reg_wr(rcd_pkg::ADDR_MISC_OSC, 8'h03);
        reg_wr(rcd_pkg::ADDR_CPU_MODE, 8'h00);
        repeat (2) @(negedge sys_clk);
        chk("main drive on", 8'h01, {7'h00, main_osc_output});
        half_chk("main high half", rcd_pkg::HALF_2);
        reg_wr(rcd_pkg::ADDR_CPU_MODE, 8'h40);
        half_chk("main middle half", rcd_pkg::HALF_8);
        reg_wr(rcd_pkg::ADDR_CPU_MODE, 8'hC0);
        half_chk("main double half", rcd_pkg::HALF_1);
        reg_wr(rcd_pkg::ADDR_CPU_MODE, 8'h80);
        rd_chk("ring_div forced", rcd_pkg::ADDR_RING_DIV, {6'h00, rcd_pkg::RDIV_8});
        half_chk("ring back half", rcd_pkg::HALF_8);
        // Stop detection without internal reset; status bit is read only.
        reg_wr(rcd_pkg::ADDR_MISC_OSC, 8'h04);
        rd_chk("status read only", rcd_pkg::ADDR_MISC_OSC, 8'h00);
        main_run = 1'b0;
        reg_wr(rcd_pkg::ADDR_MISC_OSC, 8'h01);
        repeat (150) @(posedge sys_clk);
        rd_chk("status set", rcd_pkg::ADDR_MISC_OSC, 8'h05);
        chk("no int reset", 8'h00, 8'(irst_cnt));
        reg_wr(rcd_pkg::ADDR_MISC_OSC, 8'h00);
        rd_chk("status cleared", rcd_pkg::ADDR_MISC_OSC, 8'h00);
        // Stop detection with internal reset.
        reg_wr(rcd_pkg::ADDR_MISC_OSC, 8'h03);
        reg_wr(rcd_pkg::ADDR_CPU_MODE, 8'h01);
        repeat (150) @(posedge sys_clk);
        chk("int reset pulses", 8'h01, 8'(irst_cnt));
        rd_chk("misc kept", rcd_pkg::ADDR_MISC_OSC, 8'h07);
        rd_chk("cpu_mode reset", rcd_pkg::ADDR_CPU_MODE, rcd_pkg::CPU_MODE_RST);
        half_chk("ring after stop reset", rcd_pkg::HALF_8);
        // External reset clears the status.
        do_reset();
        rd_chk("status ext reset", rcd_pkg::ADDR_MISC_OSC, 8'h00);
        wrap_up();
    end
endmodule : test_ring_clock_divider_and_osc_stop_detect
